// *** slt_defines.svh ***
// offsets, field positions, reset values and timing counts of the segment lcd timing block
`ifndef SLT_DEFINES_SVH
`define SLT_DEFINES_SVH

`define SLT_OFS_CONFIG 8'h95
`define SLT_OFS_CLOCK 8'h96
`define SLT_OFS_SEG_EN_HIGH 8'h97
`define SLT_OFS_POINTER 8'hac
`define SLT_OFS_DATA 8'hae
`define SLT_OFS_SEG_EN_LOW 8'hed

`define SLT_CFG_CLEAR_BIT 6
`define SLT_CFG_LCD_CLOCK_SELECT_BIT 3
`define SLT_CFG_BIAS_BIT 2
`define SLT_CFG_MUX_HI 1
`define SLT_CFG_MUX_LO 0
`define SLT_PTR_WRITE_BIT 7
`define SLT_PTR_ADDR_HI 5
`define SLT_SEG_EN_HIGH_MASK 8'hfc
`define SLT_SEG_EN_LOW_MASK 8'h0f
`define SLT_CFG_MASK 8'h0f
`define SLT_CLK_MASK 8'h0f
`define SLT_PTR_MASK 8'hbf
`define SLT_RESET_BYTE 8'h00

`define SLT_MEM_BYTES 15
`define SLT_MEM_LAST 6'h0e

`define SLT_MCLK_HZ 50000000
`define SLT_BASE_HZ 4096
`define SLT_BASE_CYCLES (`SLT_MCLK_HZ / `SLT_BASE_HZ)
`define SLT_SLOW_PRESCALE 5'h10

`endif

// *** slt_pkg.sv ***
// types shared by the segment lcd timing block
package slt_pkg;
    typedef enum logic [1:0] {
        SLT_MUX_STATIC,
        SLT_MUX_2X,
        SLT_MUX_3X,
        SLT_MUX_4X
    } slt_mux_t;

    typedef enum logic {
        SLT_PHASE_FIRST,
        SLT_PHASE_SECOND
    } slt_phase_t;
endpackage : slt_pkg

// *** slt_links_if.sv ***
// carriers between the top module, the frame timer and the segment memory
`timescale 1ns/10ps
interface slt_tim_if;
    logic clock_sel;
    slt_pkg::slt_mux_t mux_level;
    logic [3:0] fd_code;
    logic [1:0] com_index;
    logic polarity;
    logic com_step;
    modport ctl (output clock_sel, mux_level, fd_code, input com_index, polarity, com_step);
    modport tim (input clock_sel, mux_level, fd_code, output com_index, polarity, com_step);
endinterface : slt_tim_if

interface slt_mem_if;
    logic wr_en;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic clear;
    logic [119:0] image;
    modport ctl (output wr_en, addr, wdata, clear, input rdata, image);
    modport mem (input wr_en, addr, wdata, clear, output rdata, image);
endinterface : slt_mem_if

// *** slt_frame_timer.sv ***
// frame timer: lcd clock enables, half-slot divider, polarity and common-line stepping
`timescale 1ns/10ps
`include "slt_defines.svh"
module slt_frame_timer #(
    parameter int BASE_CYCLES = `SLT_BASE_CYCLES
) (
    input wire logic mclk, // system clock
    input wire logic rst_n, // asynchronous reset, active low
    slt_tim_if.tim tif // configuration in, timing out
);
    logic [15:0] base_cnt;
    logic [4:0] pre_cnt;
    logic [7:0] half_cnt;
    logic [7:0] half_len;
    logic [1:0] com_last;
    slt_pkg::slt_phase_t phase;
    logic base_tick;
    logic src_tick;
    logic half_done;
    logic [7:0] n_plus1;

    // base tick at twice the 2048 hz lcd clock, so the inversion half-slot is whole ticks
    assign base_tick = (base_cnt == 16'(BASE_CYCLES - 1));
    // 128 hz source is the 2048 hz source divided by sixteen
    assign src_tick = base_tick && (!tif.clock_sel || (pre_cnt == `SLT_SLOW_PRESCALE - 5'h01));
    assign n_plus1 = {4'h0, tif.fd_code} + 8'h01;

    // half-slot length in source ticks equals the slot length in lcd clock periods
    always_comb begin
        half_len = 8'h04;
        if (!tif.clock_sel) begin
            if (tif.mux_level == slt_pkg::SLT_MUX_3X || tif.mux_level == slt_pkg::SLT_MUX_4X) begin
                if (tif.fd_code == 4'h0) begin
                    half_len = 8'h40;
                end else if (tif.fd_code == 4'h1 && tif.mux_level == slt_pkg::SLT_MUX_3X) begin
                    half_len = 8'h06;
                end else begin
                    half_len = 8'(n_plus1 << 1);
                end
            end else begin
                half_len = (tif.fd_code == 4'h0) ? 8'h80 : 8'(n_plus1 << 2);
            end
        end else begin
            case (tif.fd_code)
                4'h0: half_len = 8'h02;
                4'hf: half_len = 8'h01;
                default: begin
                    if (tif.mux_level == slt_pkg::SLT_MUX_3X || tif.mux_level == slt_pkg::SLT_MUX_4X) begin
                        half_len = 8'h04;
                    end else if (tif.fd_code == 4'h1) begin
                        half_len = 8'h04;
                    end else if (tif.fd_code == 4'h2) begin
                        half_len = 8'h06;
                    end else begin
                        half_len = 8'h08;
                    end
                end
            endcase
        end
    end

    assign half_done = src_tick && (half_cnt >= half_len - 8'h01);
    assign com_last = (tif.mux_level == slt_pkg::SLT_MUX_4X) ? 2'h3 :
                      (tif.mux_level == slt_pkg::SLT_MUX_3X) ? 2'h2 : 2'h1;
    assign tif.com_step = half_done && (phase == slt_pkg::SLT_PHASE_SECOND);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            base_cnt <= 16'h0000;
            pre_cnt <= 5'h00;
        end else begin
            base_cnt <= base_tick ? 16'h0000 : base_cnt + 16'h0001;
            if (base_tick) begin
                pre_cnt <= (pre_cnt == `SLT_SLOW_PRESCALE - 5'h01) ? 5'h00 : pre_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            half_cnt <= 8'h00;
            phase <= slt_pkg::SLT_PHASE_FIRST;
            tif.polarity <= 1'b0;
            tif.com_index <= 2'h0;
        end else if (half_done) begin
            half_cnt <= 8'h00;
            tif.polarity <= ~tif.polarity;
            phase <= (phase == slt_pkg::SLT_PHASE_FIRST) ? slt_pkg::SLT_PHASE_SECOND : slt_pkg::SLT_PHASE_FIRST;
            if (tif.com_step) begin
                tif.com_index <= (tif.com_index >= com_last) ? 2'h0 : tif.com_index + 2'h1;
            end
        end else if (src_tick) begin
            half_cnt <= half_cnt + 8'h01;
        end
    end
endmodule : slt_frame_timer

// *** slt_seg_mem.sv ***
// segment data memory: fifteen bytes, one write port, one read port and a full image
`timescale 1ns/10ps
`include "slt_defines.svh"
module slt_seg_mem #(
    parameter int BYTES = `SLT_MEM_BYTES
) (
    input wire logic mclk, // system clock
    input wire logic rst_n, // asynchronous reset, active low
    slt_mem_if.mem mif // access from the register side
);
    logic [7:0] mem [BYTES];
    logic addr_ok;

    assign addr_ok = (mif.addr <= `SLT_MEM_LAST);
    assign mif.rdata = addr_ok ? mem[mif.addr[3:0]] : `SLT_RESET_BYTE;

    for (genvar i = 0; i < BYTES; i++) begin : g_byte
        assign mif.image[i*8 +: 8] = mem[i];
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                mem[i] <= `SLT_RESET_BYTE;
            end else if (mif.clear) begin
                mem[i] <= `SLT_RESET_BYTE;
            end else if (mif.wr_en && addr_ok && (mif.addr[3:0] == 4'(i))) begin
                mem[i] <= mif.wdata;
            end
        end
    end
endmodule : slt_seg_mem

// *** slt_lcd_top.sv ***
// segment lcd timing and access: special function registers, pin routing and segment drive
`timescale 1ns/10ps
`include "slt_defines.svh"
module slt_lcd_top #(
    parameter int BASE_CYCLES = `SLT_BASE_CYCLES
) (
    input wire logic mclk, // system clock, 50 MHz
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic [7:0] sfr_addr, // register address
    input wire logic sfr_wr, // register write strobe
    input wire logic [7:0] sfr_wdata, // register write data
    output logic [7:0] sfr_rdata, // register read data
    output logic [28:0] seg_lcd_mode, // 1 = pin serves as lcd segment
    output logic common_line_2, // shared pin acts as common 2
    output logic common_line_3, // shared pin acts as common 3
    output logic [3:0] common_active, // one-hot active common line
    output logic drive_polarity, // waveform polarity
    output logic [28:0] seg_pixel, // segment on state for active common
    output logic bias_select // bias bit toward the voltage generator
);
    slt_tim_if tif ();
    slt_mem_if mif ();

    logic [7:0] display_config_register;
    logic [7:0] display_clock_register;
    logic [7:0] segment_enable_high;
    logic [7:0] segment_enable_low;
    logic [7:0] segment_memory_pointer;
    logic [7:0] segment_memory_data;
    logic [7:0] next_segment_memory_data;
    logic [28:0] next_seg_pixel;
    logic [28:0] next_seg_lcd_mode;
    logic [3:0] next_common_active;
    logic [3:0] nibble [29];

    logic wr_config;
    logic wr_clock;
    logic wr_seg_high;
    logic wr_seg_low;
    logic wr_pointer;
    logic wr_data;
    logic ptr_is_write;
    logic segment_memory_clear_bit;
    logic lcd_clock_select;
    logic [3:0] frame_divider_code;
    slt_pkg::slt_mux_t multiplex_level_field;

    // register decode
    assign wr_config = sfr_wr && (sfr_addr == `SLT_OFS_CONFIG);
    assign wr_clock = sfr_wr && (sfr_addr == `SLT_OFS_CLOCK);
    assign wr_seg_high = sfr_wr && (sfr_addr == `SLT_OFS_SEG_EN_HIGH);
    assign wr_seg_low = sfr_wr && (sfr_addr == `SLT_OFS_SEG_EN_LOW);
    assign wr_pointer = sfr_wr && (sfr_addr == `SLT_OFS_POINTER);
    assign wr_data = sfr_wr && (sfr_addr == `SLT_OFS_DATA);
    assign ptr_is_write = sfr_wdata[`SLT_PTR_WRITE_BIT];

    // the clear bit acts on the write itself and is never stored
    assign segment_memory_clear_bit = wr_config && sfr_wdata[`SLT_CFG_CLEAR_BIT];

    assign lcd_clock_select = display_config_register[`SLT_CFG_LCD_CLOCK_SELECT_BIT];
    assign multiplex_level_field = slt_pkg::slt_mux_t'(display_config_register[`SLT_CFG_MUX_HI:`SLT_CFG_MUX_LO]);
    assign frame_divider_code = display_clock_register[3:0];
    assign bias_select = display_config_register[`SLT_CFG_BIAS_BIT];

    // timing configuration toward the frame timer
    assign tif.clock_sel = lcd_clock_select;
    assign tif.mux_level = multiplex_level_field;
    assign tif.fd_code = frame_divider_code;

    // memory access starts on the pointer write, addressed by the value being written
    assign mif.addr = sfr_wdata[`SLT_PTR_ADDR_HI:0];
    assign mif.wr_en = wr_pointer && ptr_is_write;
    assign mif.wdata = segment_memory_data;
    assign mif.clear = segment_memory_clear_bit;

    // a read-direction pointer write loads the data register; a software write to it wins otherwise
    assign next_segment_memory_data = (wr_pointer && !ptr_is_write) ? mif.rdata :
                                      wr_data ? sfr_wdata : segment_memory_data;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            display_config_register <= `SLT_RESET_BYTE;
            display_clock_register <= `SLT_RESET_BYTE;
            segment_enable_high <= `SLT_RESET_BYTE;
            segment_enable_low <= `SLT_RESET_BYTE;
            segment_memory_pointer <= `SLT_RESET_BYTE;
            segment_memory_data <= `SLT_RESET_BYTE;
        end else begin
            if (wr_config) begin
                display_config_register <= sfr_wdata & `SLT_CFG_MASK;
            end
            if (wr_clock) begin
                display_clock_register <= sfr_wdata & `SLT_CLK_MASK;
            end
            if (wr_seg_high) begin
                segment_enable_high <= sfr_wdata & `SLT_SEG_EN_HIGH_MASK;
            end
            if (wr_seg_low) begin
                segment_enable_low <= sfr_wdata & `SLT_SEG_EN_LOW_MASK;
            end
            if (wr_pointer) begin
                segment_memory_pointer <= sfr_wdata & `SLT_PTR_MASK;
            end
            segment_memory_data <= next_segment_memory_data;
        end
    end

    // register read mux; unmapped addresses read zero
    always_comb begin
        case (sfr_addr)
            `SLT_OFS_CONFIG: sfr_rdata = display_config_register;
            `SLT_OFS_CLOCK: sfr_rdata = display_clock_register;
            `SLT_OFS_SEG_EN_HIGH: sfr_rdata = segment_enable_high;
            `SLT_OFS_SEG_EN_LOW: sfr_rdata = segment_enable_low;
            `SLT_OFS_POINTER: sfr_rdata = segment_memory_pointer;
            `SLT_OFS_DATA: sfr_rdata = segment_memory_data;
            default: sfr_rdata = `SLT_RESET_BYTE;
        endcase
    end

    // pin routing
    assign common_line_2 = (multiplex_level_field == slt_pkg::SLT_MUX_3X) ||
                           (multiplex_level_field == slt_pkg::SLT_MUX_4X);
    assign common_line_3 = (multiplex_level_field == slt_pkg::SLT_MUX_4X);

    assign next_seg_lcd_mode[15:0] = 16'hffff;
    assign next_seg_lcd_mode[19:16] = segment_enable_low[3:0];
    assign next_seg_lcd_mode[25:20] = segment_enable_high[7:2];
    assign next_seg_lcd_mode[26] = 1'b1;
    assign next_seg_lcd_mode[27] = !common_line_3;
    assign next_seg_lcd_mode[28] = !common_line_2;

    // each memory byte splits into the even segment in the low nibble and the odd one above
    for (genvar s = 0; s < 29; s++) begin : g_seg
        assign nibble[s] = mif.image[(s/2)*8 + (s%2)*4 +: 4];
        assign next_seg_pixel[s] = nibble[s][tif.com_index] && next_seg_lcd_mode[s];
    end

    assign next_common_active = 4'(4'h1 << tif.com_index);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seg_pixel <= 29'h0000000;
            seg_lcd_mode <= 29'h0000000;
            common_active <= 4'h0;
            drive_polarity <= 1'b0;
        end else begin
            seg_pixel <= next_seg_pixel;
            seg_lcd_mode <= next_seg_lcd_mode;
            common_active <= next_common_active;
            drive_polarity <= tif.polarity;
        end
    end

    slt_frame_timer #(
        .BASE_CYCLES(BASE_CYCLES)
    ) u_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .tif(tif.tim)
    );

    slt_seg_mem #(
        .BYTES(`SLT_MEM_BYTES)
    ) u_mem (
        .mclk(mclk),
        .rst_n(rst_n),
        .mif(mif.mem)
    );
endmodule : slt_lcd_top

// *** slt_glass_model.sv ***
// passive glass: times the common steps and polarity flips that reach it
`timescale 1ns/10ps
module slt_glass_model (
    input wire logic mclk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic restart, // clears step count and commons seen
    input wire logic [3:0] common_active, // driven common
    input wire logic drive_polarity, // waveform polarity
    output int pol_gap, // cycles between flips
    output int com_gap, // cycles between steps
    output int com_events, // steps seen
    output logic [3:0] com_seen // commons seen once settled
);
    int now = 0;
    int pol_t = 0;
    int com_t = 0;
    logic [3:0] com_q = 4'h0;
    logic pol_q = 1'b0;
    always @(posedge mclk) begin
        now <= now + 1;
        pol_q <= drive_polarity;
        com_q <= common_active;
        if (!rst_n || restart) begin
            com_events <= 0;
            com_seen <= 4'h0;
        end else begin
            if (drive_polarity !== pol_q) begin
                pol_gap <= now - pol_t;
                pol_t <= now;
            end
            if (common_active !== com_q) begin
                com_gap <= now - com_t;
                com_t <= now;
                com_events <= com_events + 1;
                // the first step may end a slot cut short by a new setting
                if (com_events >= 1) com_seen <= com_seen | common_active;
            end
        end
    end
endmodule : slt_glass_model

// *** slt_lcd_top_assertions.sv ***
// concurrent checks on the ports of the segment lcd timing block
`timescale 1ns/10ps
`include "slt_defines.svh"
module slt_lcd_top_checker #(
    parameter int BASE_CYCLES = `SLT_BASE_CYCLES
) (
    input wire logic mclk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic [7:0] sfr_addr, // address
    input wire logic sfr_wr, // write strobe
    input wire logic [7:0] sfr_wdata, // write data
    input wire logic [7:0] sfr_rdata, // read data
    input wire logic [28:0] seg_lcd_mode, // pin modes
    input wire logic common_line_2, // shared common 2
    input wire logic common_line_3, // shared common 3
    input wire logic [3:0] common_active, // active common
    input wire logic drive_polarity, // polarity
    input wire logic [28:0] seg_pixel, // segment data
    input wire logic bias_select // bias
);
    logic [3:0] cfg_q;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // mirror of the kept configuration bits
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= 4'h0;
        end else if (sfr_wr && sfr_addr == 8'h95) begin
            cfg_q <= sfr_wdata[3:0];
        end
    end
    a_com_one_hot: assert property ($past(rst_n) |-> $onehot(common_active))
        else $error("active common not one-hot");
    a_shared_common_line_2: assert property (common_line_2 == cfg_q[1])
        else $error("common 2 select wrong");
    a_shared_common_line_3: assert property (common_line_3 == (cfg_q[1:0] == 2'h3))
        else $error("common 3 select wrong");
    a_pin_release: assert property ($past(rst_n) |-> seg_lcd_mode[28:27] == ~$past({common_line_2, common_line_3}))
        else $error("shared pin mode wrong");
    a_fixed_segments: assert property ($past(rst_n) |-> seg_lcd_mode[15:0] == 16'hffff && seg_lcd_mode[26])
        else $error("fixed segment not driven");
    a_enable_high: assert property (sfr_wr && sfr_addr == 8'h97 |-> ##2 seg_lcd_mode[25:20] == $past(sfr_wdata[7:2], 2))
        else $error("high enables not routed");
    a_enable_low: assert property (sfr_wr && sfr_addr == 8'hed |-> ##2 seg_lcd_mode[19:16] == $past(sfr_wdata[3:0], 2))
        else $error("low enables not routed");
    a_pol_with_com: assert property ($past(rst_n, 2) && $changed(common_active) |-> $changed(drive_polarity))
        else $error("common step without polarity flip");
    a_clear_mem: assert property (sfr_wr && sfr_addr == 8'h95 && sfr_wdata[6] |-> ##2 (seg_pixel == 29'h0) [*2])
        else $error("segment data not cleared");
    a_config_read: assert property (sfr_addr == 8'h95 |-> sfr_rdata == {4'h0, cfg_q} && bias_select == cfg_q[2])
        else $error("configuration read wrong");
    c_four_commons: cover property (common_active == 4'h8);
    c_clear: cover property (sfr_wr && sfr_addr == 8'h95 && sfr_wdata[6]);
    c_common_line_3_bias: cover property (common_line_3 && bias_select);
endmodule : slt_lcd_top_checker
bind slt_lcd_top slt_lcd_top_checker #(.BASE_CYCLES(BASE_CYCLES)) u_checker (.mclk(mclk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .seg_lcd_mode(seg_lcd_mode), .common_line_2(common_line_2), .common_line_3(common_line_3),
    .common_active(common_active), .drive_polarity(drive_polarity), .seg_pixel(seg_pixel),
    .bias_select(bias_select));

// *** slt_lcd_top_bench.sv ***
// self-checking bench for the segment lcd timing block
`timescale 1ns/10ps
module slt_lcd_top_bench;
    localparam int BASE = 4;
    logic mclk;
    logic rst_n;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic [28:0] seg_lcd_mode;
    logic common_line_2;
    logic common_line_3;
    logic [3:0] common_active;
    logic drive_polarity;
    logic [28:0] seg_pixel;
    logic bias_select;
    logic restart;
    int pol_gap, com_gap, com_events;
    logic [3:0] com_seen;
    int n_mismatch = 0;
    int total_checks = 0;
    logic [7:0] lfsr = 8'h35;
    logic [7:0] mem_m [15];
    logic [7:0] regs [7] = '{8'h95, 8'h96, 8'h97, 8'hac, 8'hae, 8'hed, 8'h90};
    // {clock select, multiplex, divider} corner settings
    logic [7:0] seq [12] = '{8'h10, 8'h21, 8'h30, 8'h51, 8'h52, 8'h50, 8'h7f, 8'h67, 8'h59, 8'h31, 8'h00, 8'h44};
    slt_lcd_top #(.BASE_CYCLES(BASE)) dut (.mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .seg_lcd_mode(seg_lcd_mode), .common_line_2(common_line_2),
        .common_line_3(common_line_3), .common_active(common_active), .drive_polarity(drive_polarity),
        .seg_pixel(seg_pixel), .bias_select(bias_select));
    slt_glass_model glass (.mclk(mclk), .rst_n(rst_n), .restart(restart), .common_active(common_active),
        .drive_polarity(drive_polarity), .pol_gap(pol_gap), .com_gap(com_gap), .com_events(com_events),
        .com_seen(com_seen));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    function automatic logic [7:0] lfsr_step(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_step
    function automatic int half_len(logic cs, logic [1:0] m, logic [3:0] fd);
        if (!cs) begin
            // multiplex field 00 runs as 2x
            if (!m[1]) return (fd == 4'h0) ? 128 : 4 * (fd + 1);
            if (m == 2'h2 && fd == 4'h1) return 6;
            return (fd == 4'h0) ? 64 : 2 * (fd + 1);
        end
        if (fd == 4'h0) return 2;
        if (fd == 4'hf) return 1;
        if (m[1]) return 4;
        return (fd == 4'h1) ? 4 : (fd == 4'h2) ? 6 : 8;
    endfunction : half_len
    function automatic logic [28:0] pix_exp(logic [3:0] ca);
        logic [28:0] r;
        int k;
        k = ca[1] ? 1 : ca[2] ? 2 : ca[3] ? 3 : 0;
        for (int s = 0; s < 29; s++) r[s] = mem_m[s / 2][(s % 2) * 4 + k];
        return r & 29'h07ffffff;
    endfunction : pix_exp
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge mclk);
        #1 sfr_wr = 1'b0;
        @(posedge mclk);
        #1;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        sfr_addr = a;
        @(negedge mclk);
        chk(sfr_rdata, exp);
        @(posedge mclk);
        #1;
    endtask : rd
    task automatic pulse_restart();
        restart = 1'b1;
        @(posedge mclk);
        #1 restart = 1'b0;
    endtask : pulse_restart
    task automatic wait_com(int need);
        for (int i = 0; i < 30000 && com_events < need; i++) @(posedge mclk);
        if (com_events < need) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: no common step", $time);
            summarize();
        end
        #1;
    endtask : wait_com
    initial begin
        logic [7:0] d;
        logic [7:0] r;
        int n, len, t;
        rst_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        restart = 1'b0;
        repeat (6) @(posedge mclk);
        #1 rst_n = 1'b1;
        @(posedge mclk);
        #1;
        foreach (regs[i]) rd(regs[i], 8'h00);
        chk(seg_lcd_mode, 29'h1c00ffff);
        chk({common_line_3, common_line_2}, 2'b00);
        chk(common_active, 4'h1);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            lfsr = lfsr_step(lfsr);
            d = (i == 4) ? 8'hff : lfsr;
            wr(8'h97, d);
            wr(8'hed, ~d);
            rd(8'h97, d & 8'hfc);
            rd(8'hed, ~d & 8'h0f);
            chk(seg_lcd_mode[25:16], {d[7:2], ~d[3:0]});
        end
        wr(8'hed, 8'h0f);
        $display("test enables done");
        for (int a = 0; a < 15; a++) begin
            lfsr = lfsr_step(lfsr);
            mem_m[a] = lfsr;
            wr(8'hae, lfsr);
            rd(8'hae, lfsr);
            wr(8'hac, 8'h80 | 8'(a));
        end
        for (int a = 14; a >= 0; a--) begin
            wr(8'hac, 8'(a));
            rd(8'hae, mem_m[a]);
        end
        wr(8'hac, 8'hff);
        rd(8'hac, 8'hbf);
        wr(8'hac, 8'h0f);
        rd(8'hae, 8'h00);
        $display("test memory done");
        wr(8'h96, 8'h01);
        wr(8'h95, 8'h03);
        pulse_restart();
        for (int j = 1; j < 6; j++) begin
            wait_com(j);
            @(negedge mclk);
            chk(seg_pixel, pix_exp(common_active));
            @(posedge mclk);
            #1;
        end
        wr(8'h95, 8'h43);
        chk(seg_pixel, 29'h0);
        rd(8'h95, 8'h03);
        for (int a = 0; a < 15; a += 7) begin
            wr(8'hac, 8'(a));
            rd(8'hae, 8'h00);
        end
        $display("test pixels and clear done");
        for (int i = 0; i < 18; i++) begin
            lfsr = lfsr_step(lfsr);
            r = (i < 12) ? seq[i] : {1'b0, lfsr[6], lfsr[5:4], lfsr[3:0]};
            n = (r[5:4] == 2'h0) ? 2 : r[5:4] + 1;
            len = half_len(r[6], r[5:4], r[3:0]);
            t = r[6] ? 16 * BASE : BASE;
            wr(8'h96, {lfsr[7:4], r[3:0]});
            wr(8'h95, {4'h0, r[6], lfsr[0], r[5:4]});
            rd(8'h96, {4'h0, r[3:0]});
            chk({bias_select, common_line_3, common_line_2}, {lfsr[0], r[5:4] == 2'h3, r[5]});
            pulse_restart();
            wait_com(n + 2);
            chk(pol_gap, len * t);
            chk(com_gap, 2 * len * t);
            chk(com_seen, (1 << n) - 1);
        end
        $display("test timing done");
        summarize();
    end
endmodule : slt_lcd_top_bench
